// ---- rop_pkg.sv ----
// Shared constants and types for the realtime output port
package rop_pkg;

    localparam int PORT_W = 8;
    localparam int ADDR_W = 16;

    localparam logic [ADDR_W-1:0] ADDR_DATA   = 16'hffd9;
    localparam logic [ADDR_W-1:0] ADDR_DIR    = 16'hffe9;
    localparam logic [ADDR_W-1:0] ADDR_RT_EN  = 16'hfffe;

    localparam logic [PORT_W-1:0] RST_DATA    = 8'h00;
    localparam logic [PORT_W-1:0] RST_DIR     = 8'h00;
    localparam logic [PORT_W-1:0] RST_RT_EN   = 8'h00;
    localparam logic [PORT_W-1:0] RST_SLAVE   = 8'h00;
    localparam logic [PORT_W-1:0] DIR_READ    = 8'hff;
    localparam logic [PORT_W-1:0] UNMAPPED_RD = 8'h00;
    localparam logic [PORT_W-1:0] ALL_HIZ     = 8'hff;

    // Number of flops in the trigger synchroniser
    localparam int SYNC_STAGES = 2;

    // Low-power state of the chip, one-hot
    typedef enum logic [5:0] {
        PM_ACTIVE    = 6'h01,
        PM_SUBACTIVE = 6'h02,
        PM_SLEEP     = 6'h04,
        PM_SUBSLEEP  = 6'h08,
        PM_STANDBY   = 6'h10,
        PM_WATCH     = 6'h20
    } rop_pmode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PORT_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } rop_bus_req_s;

endpackage

// ---- rop_trig_sync.sv ----
// Trigger synchroniser and edge detector
`timescale 1ns/100ps
module rop_trig_sync
    import rop_pkg::*;
#(
    parameter bit RISING = 1'b1
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic trig_in,
    output logic      trig_pulse
);
    logic [SYNC_STAGES-1:0] sync_q;
    logic                   prev_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], trig_in};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q[SYNC_STAGES-1];
        end
    end

    assign trig_pulse = RISING ? (sync_q[SYNC_STAGES-1] & ~prev_q)
                               : (~sync_q[SYNC_STAGES-1] & prev_q);
endmodule // rop_trig_sync

// ---- rop_pin_cell.sv ----
// Output and read-back selection for one port pin
`timescale 1ns/100ps
module rop_pin_cell (
    input  wire logic rt_en,
    input  wire logic dir,
    input  wire logic data,
    input  wire logic slave_dir,
    input  wire logic slave_data,
    input  wire logic pin_level,
    input  wire logic pullup_en,
    input  wire logic standby,
    output logic      next_out,
    output logic      next_oe_n,
    output logic      read_bit
);
    always_comb begin
        next_out  = 1'b0;
        next_oe_n = 1'b1;
        if (standby) begin
            next_out  = pullup_en;
            next_oe_n = ~pullup_en;
        end else if (rt_en) begin
            next_out  = slave_data;
            next_oe_n = ~slave_dir;
        end else begin
            next_out  = data;
            next_oe_n = ~dir;
        end
    end

    // general reads stored bit or pin
    assign read_bit = (rt_en | dir) ? data : pin_level;
endmodule // rop_pin_cell

// ---- rop_rt_port.sv ----
// Eight-bit port with per-pin realtime output latches
`timescale 1ns/100ps
module rop_rt_port
    import rop_pkg::*;
#(
    parameter int  WIDTH       = PORT_W,
    parameter bit  TRIG_RISING = 1'b1
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire rop_bus_req_s      bus,
    output logic [WIDTH-1:0]       rdata,
    input  wire logic              realtime_trigger_input,
    input  wire rop_pmode_e        power_mode,
    input  wire logic [WIDTH-1:0]  pullup_en,
    input  wire logic [WIDTH-1:0]  pin_in,
    output logic [WIDTH-1:0]       pin_out,
    output logic [WIDTH-1:0]       pin_oe_n
);

    logic [WIDTH-1:0] port_output_data;
    logic [WIDTH-1:0] port_direction;
    logic [WIDTH-1:0] realtime_enable;
    logic [WIDTH-1:0] slave_data_latch;
    logic [WIDTH-1:0] slave_direction_latch;

    logic [WIDTH-1:0] next_slave_data;
    logic [WIDTH-1:0] next_slave_dir;
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe_n;
    logic [WIDTH-1:0] next_rdata;
    logic [WIDTH-1:0] read_bits;

    logic wr_data;
    logic wr_dir;
    logic wr_rt_en;
    logic trig_pulse;
    logic standby;
    logic hold_pins;

    assign wr_data  = bus.wr && (bus.addr == ADDR_DATA);
    assign wr_dir   = bus.wr && (bus.addr == ADDR_DIR);
    assign wr_rt_en = bus.wr && (bus.addr == ADDR_RT_EN);

    assign standby   = (power_mode == PM_STANDBY);
    // Watch mode treated like sleep: pins keep their last state
    assign hold_pins = (power_mode == PM_SLEEP)
                    || (power_mode == PM_SUBSLEEP)
                    || (power_mode == PM_WATCH);

    rop_trig_sync #(
        .RISING     (TRIG_RISING)
    ) u_trig_sync (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .trig_in    (realtime_trigger_input),
        .trig_pulse (trig_pulse)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port_output_data <= RST_DATA;
        end else if (wr_data) begin
            port_output_data <= bus.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port_direction <= RST_DIR;
        end else if (wr_dir) begin
            port_direction <= bus.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            realtime_enable <= RST_RT_EN;
        end else if (wr_rt_en) begin
            realtime_enable <= bus.wdata;
        end
    end

    // Trigger samples registers before a same-cycle write lands
    always_comb begin
        next_slave_data = slave_data_latch;
        next_slave_dir  = slave_direction_latch;
        if (trig_pulse) begin
            next_slave_data = (next_slave_data & ~realtime_enable)
                            | (port_output_data & realtime_enable);
            next_slave_dir  = (next_slave_dir & ~realtime_enable)
                            | (port_direction & realtime_enable);
        end
        if (wr_data) begin
            next_slave_data = (next_slave_data & realtime_enable)
                            | (bus.wdata & ~realtime_enable);
        end
        if (wr_dir) begin
            next_slave_dir = (next_slave_dir & realtime_enable)
                           | (bus.wdata & ~realtime_enable);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slave_data_latch      <= RST_SLAVE;
            slave_direction_latch <= RST_SLAVE;
        end else begin
            slave_data_latch      <= next_slave_data;
            slave_direction_latch <= next_slave_dir;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            rop_pin_cell u_cell (
                .rt_en      (realtime_enable[gi]),
                .dir        (port_direction[gi]),
                .data       (port_output_data[gi]),
                .slave_dir  (slave_direction_latch[gi]),
                .slave_data (slave_data_latch[gi]),
                .pin_level  (pin_in[gi]),
                .pullup_en  (pullup_en[gi]),
                .standby    (standby),
                .next_out   (next_pin_out[gi]),
                .next_oe_n  (next_pin_oe_n[gi]),
                .read_bit   (read_bits[gi])
            );
        end
    endgenerate

    // float in reset, hold in sleep
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_out  <= RST_DATA;
            pin_oe_n <= ALL_HIZ;
        end else if (!hold_pins) begin
            pin_out  <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    always_comb begin
        next_rdata = UNMAPPED_RD;
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_DATA:  next_rdata = read_bits;
                ADDR_DIR:   next_rdata = DIR_READ;
                ADDR_RT_EN: next_rdata = realtime_enable;
                default:    next_rdata = UNMAPPED_RD;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= UNMAPPED_RD;
        end else begin
            rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_data_write_stores: assert property (
        wr_data |=> port_output_data == $past(bus.wdata)
    ) else $error("data register did not take the write");

    a_dir_write_stores: assert property (
        wr_dir |=> port_direction == $past(bus.wdata)
    ) else $error("direction register did not take the write");

    a_dir_reads_ones: assert property (
        (bus.rd && bus.addr == ADDR_DIR) |=> rdata == DIR_READ
    ) else $error("direction read did not return all ones");

    a_rten_read_back: assert property (
        (bus.rd && bus.addr == ADDR_RT_EN && !wr_rt_en)
            |=> rdata == $past(realtime_enable)
    ) else $error("enable register read back wrong");

    a_after_reset_zero: assert property (
        $past(!rst_n) |-> (slave_data_latch == RST_SLAVE)
            && (slave_direction_latch == RST_SLAVE)
            && (port_output_data == RST_DATA)
            && (realtime_enable == RST_RT_EN)
    ) else $error("state not cleared by reset");

    a_reset_pins_hiz: assert property (
        $past(!rst_n) |-> pin_oe_n == ALL_HIZ
    ) else $error("pins driven after reset");

    a_trig_copies_latch: assert property (
        (trig_pulse && !wr_rt_en)
            |=> ((slave_data_latch ^ $past(port_output_data))
                    & realtime_enable) == '0
             && ((slave_direction_latch ^ $past(port_direction))
                    & realtime_enable) == '0
    ) else $error("trigger did not copy into latches");

    a_gen_write_mirror: assert property (
        (wr_data && !wr_rt_en)
            |=> ((slave_data_latch ^ $past(bus.wdata))
                    & ~realtime_enable) == '0
    ) else $error("general write missed the data latch");

    a_rt_latch_steady: assert property (
        (!trig_pulse && !wr_rt_en)
            |=> ((slave_data_latch ^ $past(slave_data_latch))
                    & realtime_enable) == '0
    ) else $error("realtime latch changed without trigger");

    a_rt_pin_drive: assert property (
        (power_mode == PM_ACTIVE)
            |=> ((pin_oe_n ^ ~$past(slave_direction_latch))
                    & $past(realtime_enable)) == '0
             && ((pin_out ^ $past(slave_data_latch))
                    & $past(realtime_enable)) == '0
    ) else $error("realtime pin not set by latches");

    a_gen_pin_drive: assert property (
        (power_mode == PM_SUBACTIVE || power_mode == PM_ACTIVE)
            |=> ((pin_oe_n ^ ~$past(port_direction))
                    & ~$past(realtime_enable)) == '0
    ) else $error("general pin enable not set by direction");

    a_rt_read_stored: assert property (
        (bus.rd && bus.addr == ADDR_DATA)
            |=> ((rdata ^ $past(port_output_data))
                    & $past(realtime_enable)) == '0
    ) else $error("realtime read did not return stored bit");

    a_gen_read_pin: assert property (
        (bus.rd && bus.addr == ADDR_DATA)
            |=> ((rdata ^ $past(pin_in))
                    & ~$past(realtime_enable)
                    & ~$past(port_direction)) == '0
    ) else $error("input pin level not returned on read");

    a_sleep_holds_pins: assert property (
        hold_pins |=> $stable(pin_out) && $stable(pin_oe_n)
    ) else $error("pins moved during sleep");

    a_standby_pullup: assert property (
        standby |=> ((pin_out ^ $past(pullup_en)) == '0)
            && (pin_oe_n == ~$past(pullup_en))
    ) else $error("standby pins wrong for pull-up");

    a_one_update_edge: assert property (
        trig_pulse |=> !trig_pulse
    ) else $error("one edge gave two latch updates");

    a_unmapped_zero: assert property (
        (bus.rd && bus.addr != ADDR_DATA && bus.addr != ADDR_DIR
            && bus.addr != ADDR_RT_EN) |=> rdata == UNMAPPED_RD
    ) else $error("unmapped read not zero");

    a_idle_rdata_zero: assert property (
        !bus.rd |=> rdata == UNMAPPED_RD
    ) else $error("read data present without a read");

    // Registers may only move on their own write strobe
    a_data_holds: assert property (
        !wr_data |=> $stable(port_output_data)
    ) else $error("data register changed without a write");

    a_dir_holds: assert property (
        !wr_dir |=> $stable(port_direction)
    ) else $error("direction register changed without a write");

    a_dir_reset_zero: assert property (
        $past(!rst_n) |-> port_direction == RST_DIR
    ) else $error("direction register not cleared by reset");

    a_rten_write_stores: assert property (
        wr_rt_en |=> realtime_enable == $past(bus.wdata)
    ) else $error("enable register did not take the write");

    a_rten_holds: assert property (
        !wr_rt_en |=> $stable(realtime_enable)
    ) else $error("enable register changed without a write");

    a_gen_dir_mirror: assert property (
        (wr_dir && !wr_rt_en)
            |=> ((slave_direction_latch ^ $past(bus.wdata))
                    & ~realtime_enable) == '0
    ) else $error("general write missed the direction latch");

    a_rt_dir_steady: assert property (
        (!trig_pulse && !wr_rt_en)
            |=> ((slave_direction_latch ^ $past(slave_direction_latch))
                    & realtime_enable) == '0
    ) else $error("realtime direction latch moved without trigger");

    a_gen_pin_data: assert property (
        (power_mode == PM_SUBACTIVE || power_mode == PM_ACTIVE)
            |=> ((pin_out ^ $past(port_output_data))
                    & ~$past(realtime_enable)) == '0
    ) else $error("general pin value not set by data register");

    a_rt_sub_drive: assert property (
        (power_mode == PM_SUBACTIVE)
            |=> ((pin_oe_n ^ ~$past(slave_direction_latch))
                    & $past(realtime_enable)) == '0
             && ((pin_out ^ $past(slave_data_latch))
                    & $past(realtime_enable)) == '0
    ) else $error("realtime pin not set by latches in subactive");

    a_standby_floats: assert property (
        standby |=> (pin_oe_n | $past(pullup_en)) == '1
    ) else $error("pin driven in standby without pull-up");

    a_reset_pin_low: assert property (
        $past(!rst_n) |-> pin_out == RST_DATA && rdata == UNMAPPED_RD
    ) else $error("pin data or read data not cleared by reset");

    // Pulse lags the pin by the two synchroniser flops
    a_trig_latency: assert property (
        trig_pulse |-> $past(realtime_trigger_input, 2) == TRIG_RISING
    ) else $error("latch update without a trigger edge");

endmodule // rop_rt_port

// ---- rop_far_side.sv ----
// Trigger source and board pin loads facing the port
`timescale 1ns/100ps
module rop_far_side (
    input  wire logic       mclk,
    input  wire logic       fire,
    input  wire logic [7:0] board_val,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    output logic      [7:0] pin_in,
    output logic            trig
);
    logic [2:0] hold_cnt;

    initial begin
        trig = 1'b0;
        hold_cnt = 3'h0;
    end

    // four-cycle levels, so no edges merge
    always @(posedge mclk) begin
        if (fire) begin
            trig <= 1'b1;
            hold_cnt <= 3'h4;
        end else if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
            trig <= (hold_cnt != 3'h1);
        end
    end

    // Board drives only where the port lets go
    assign pin_in = (pin_oe_n & board_val) | (~pin_oe_n & pin_out);
endmodule // rop_far_side

// ---- rop_rt_port_test.sv ----
// Self-checking bench for the realtime output port
`timescale 1ns/100ps
module rop_rt_port_test;
    import rop_pkg::*;
    logic         mclk;
    logic         rst_n;
    rop_bus_req_s bus;
    logic [7:0]   rdata;
    logic         trig;
    rop_pmode_e   power_mode;
    logic [7:0]   pullup_en;
    logic [7:0]   pin_in;
    logic [7:0]   pin_out;
    logic [7:0]   pin_oe_n;
    logic         fire;
    logic [7:0]   board_val;
    logic [7:0]   m_data, m_dir, m_en, s_data, s_dir, rnd, k_oe, k_drv;
    int           bad_count;
    int           tests_run;

    rop_rt_port i_dut (.mclk(mclk), .rst_n(rst_n), .bus(bus),
        .rdata(rdata), .realtime_trigger_input(trig),
        .power_mode(power_mode), .pullup_en(pullup_en), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    rop_far_side i_far (.mclk(mclk), .fire(fire), .board_val(board_val),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
        .trig(trig));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] exp_oe();
        return ~((m_en & s_dir) | (~m_en & m_dir));
    endfunction
    function automatic logic [7:0] exp_drv();
        return (m_en & s_data) | (~m_en & m_data);
    endfunction
    function automatic logic [7:0] rd_exp();
        return ((m_en | m_dir) & m_data) | (~(m_en | m_dir) & board_val);
    endfunction

    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    // Mirror follows the write; general bits' latches too
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        if (a == ADDR_DATA) begin
            m_data = v;
            s_data = (s_data & m_en) | (v & ~m_en);
        end else if (a == ADDR_DIR) begin
            m_dir = v;
            s_dir = (s_dir & m_en) | (v & ~m_en);
        end else if (a == ADDR_RT_EN) begin
            m_en = v;
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    task automatic pins(input logic [7:0] oe, input logic [7:0] drv);
        @(posedge mclk);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("pin_oe_n", oe, pin_oe_n);
        chk("pin_out", drv & ~oe, pin_out & ~oe);
    endtask
    // Trigger is slow to land, so nothing else moves meanwhile
    task automatic fire_trig();
        @(posedge mclk);
        bus.wr <= 1'b0;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (8) @(posedge mclk);
        s_data = (s_data & ~m_en) | (m_data & m_en);
        s_dir = (s_dir & ~m_en) | (m_dir & m_en);
    endtask
    task automatic clear_mirror();
        {m_data, m_dir, m_en, s_data, s_dir} = '0;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        power_mode = PM_ACTIVE;
        pullup_en = 8'h00;
        fire = 1'b0;
        board_val = 8'h5a;
        rnd = 8'h39;
        bad_count = 0;
        tests_run = 0;
        clear_mirror();
        repeat (7) @(posedge mclk);
        #1;
        chk("pin_oe_n", ALL_HIZ, pin_oe_n);
        @(posedge mclk);
        rst_n <= 1'b1;
        rd(ADDR_RT_EN, 8'h00);
        rd(ADDR_DIR, 8'hff);
        rd(16'hffda, 8'h00);
        rd(ADDR_DATA, rd_exp());
        wr(ADDR_RT_EN, 8'hff);
        rd(ADDR_DATA, 8'h00);
        pins(exp_oe(), exp_drv());
        wr(ADDR_RT_EN, 8'h0f);
        wr(ADDR_DATA, 8'ha5);
        wr(ADDR_DIR, 8'hf0);
        pins(exp_oe(), exp_drv());
        fire_trig();
        pins(exp_oe(), exp_drv());
        wr(ADDR_DIR, 8'h3c);
        wr(ADDR_DATA, 8'h96);
        pins(exp_oe(), exp_drv());
        rd(ADDR_DATA, rd_exp());
        for (int i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            @(posedge mclk);
            board_val <= rnd ^ 8'ha5;
            case (rnd[1:0])
                2'h0: wr(ADDR_DATA, lfsr(rnd));
                2'h1: wr(ADDR_DIR, lfsr(rnd));
                2'h2: wr(ADDR_RT_EN, lfsr(rnd));
                default: fire_trig();
            endcase
            pins(exp_oe(), exp_drv());
            rd(ADDR_DATA, rd_exp());
            rd(ADDR_RT_EN, m_en);
        end
        k_oe = exp_oe();
        k_drv = exp_drv();
        @(posedge mclk);
        power_mode <= PM_SLEEP;
        wr(ADDR_DATA, ~m_data);
        wr(ADDR_DIR, ~m_dir);
        pins(k_oe, k_drv);
        @(posedge mclk);
        power_mode <= PM_SUBSLEEP;
        pins(k_oe, k_drv);
        @(posedge mclk);
        power_mode <= PM_WATCH;
        pins(k_oe, k_drv);
        @(posedge mclk);
        power_mode <= PM_STANDBY;
        pullup_en <= 8'h96;
        pins(8'h69, 8'h96);
        @(posedge mclk);
        power_mode <= PM_SUBACTIVE;
        pins(exp_oe(), exp_drv());
        // Second reset in mid-run
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("pin_oe_n", ALL_HIZ, pin_oe_n);
        @(posedge mclk);
        rst_n <= 1'b1;
        clear_mirror();
        rd(ADDR_RT_EN, 8'h00);
        wr(ADDR_RT_EN, 8'hff);
        pins(exp_oe(), exp_drv());
        summarize();
    end
endmodule // rop_rt_port_test
